/* File: trl_defs.vh */
// Constants for the TMDS receive rate and lock controller
`ifndef TRL_DEFS_VH
`define TRL_DEFS_VH

// Register byte offsets
`define TRL_OFS_CTRL     8'h00
`define TRL_OFS_STATUS   8'h04
`define TRL_OFS_IRQ_STAT 8'h08
`define TRL_OFS_IRQ_CLR  8'h0C
`define TRL_OFS_IRQ_EN   8'h10

// Control register fields
`define TRL_CTRL_SYM4    0
`define TRL_CTRL_RATIO40 1
`define TRL_CTRL_RCFHOLD 2
`define TRL_CTRL_RESET   4'h0

// Interrupt event bits
`define TRL_EV_MODE      0
`define TRL_EV_LOCK      1
`define TRL_EV_UNLOCK    2
`define TRL_EV_W         3

// Minimum link rates in Mbps, per interface width
`define TRL_MIN_RATE_20  16'd611
`define TRL_MIN_RATE_40  16'd1000

// Reference clock multipliers for the link PLL
`define TRL_MULT_X1      3'h1
`define TRL_MULT_X4      3'h4
`define TRL_MULT_X5      3'h5

// Symbols per clock encodings
`define TRL_SYM2         3'h2
`define TRL_SYM4         3'h4

// Parallel data widths: symbols per clock times thirty
`define TRL_PDW_SYM2     8'h3C
`define TRL_PDW_SYM4     8'h78

// Measurement window: 10 us, so edge count equals bit rate in Mbps at 1/10
`define TRL_WIN_NS       10000
`define TRL_CLK_MHZ      200
// Analog reset hold time
`define TRL_ARST_NS      1000

// AXI responses
`define TRL_RESP_OK      2'h0
`define TRL_RESP_SLVERR  2'h2

`endif

/* File: trl_sync.v */
// Two-flop synchroniser for a group of level signals
`timescale 1ns/1ps
`default_nettype none
module trl_sync #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         resetn_i,
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);
  reg [W-1:0] meta_q; // First stage, read only by q_o

  // Two stages against metastability
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= {W{1'b0}};
      q_o    <= {W{1'b0}};
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* File: trl_rate_lock_ctrl.v */
// TMDS receive rate detection, oversampling decision and CDR lock control
// How it works
// - 20-bit, 2 symbols: minimum 611 Mbps
// - 40-bit, 4 symbols: minimum 1000 Mbps
// - Below minimum rate, use oversampling mode
// - Force data lock held zero always
// - Parallel clock source follows lock mode
// - Analog reset high holds CDR, deserializer
// - Digital reset high resets receive data path
// - Calibration active during calibration or reconfig hold
// - Parallel data width is symbols times thirty
// - Byte deserializer only for four symbols
`timescale 1ns/1ps
`default_nettype none
`include "trl_defs.vh"
module trl_rate_lock_ctrl #(
  parameter NCH = 3,  // TMDS data channels
  parameter RW  = 16  // Rate measurement width
) (
  input  wire             clk_i,
  input  wire             resetn_i,
  // AXI4-Lite slave
  input  wire [7:0]       s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output reg              s_axi_awready,
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output reg              s_axi_wready,
  output reg  [1:0]       s_axi_bresp,
  output reg              s_axi_bvalid,
  input  wire             s_axi_bready,
  input  wire [7:0]       s_axi_araddr,
  input  wire             s_axi_arvalid,
  output reg              s_axi_arready,
  output reg  [31:0]      s_axi_rdata,
  output reg  [1:0]       s_axi_rresp,
  output reg              s_axi_rvalid,
  input  wire             s_axi_rready,
  // Link side
  input  wire             tmds_clk_i,
  input  wire [NCH-1:0]   cdr_ref_locked_i,
  input  wire [NCH-1:0]   cdr_data_locked_i,
  input  wire [NCH-1:0]   cal_busy_i,
  // Transceiver control
  output reg  [NCH-1:0]   force_ref_lock_o,
  output reg  [NCH-1:0]   force_data_lock_o,
  output reg  [NCH-1:0]   pclk_from_ref_o,
  output reg  [NCH-1:0]   analog_reset_o,
  output reg  [NCH-1:0]   digital_reset_o,
  output reg  [NCH-1:0]   lock_to_rstctl_o,
  output reg              cal_active_o,
  output reg              oversample_o,
  output reg              byte_deser_en_o,
  output reg  [2:0]       sym_per_clk_o,
  output reg  [7:0]       par_data_width_o,
  output reg  [2:0]       refclk_mult_o,
  output reg              cdr_refclk_sel_o,
  output reg              irq_o
);
  // Derived cycle counts, rounded up
  localparam integer WIN_CYC  = (`TRL_WIN_NS * `TRL_CLK_MHZ + 999) / 1000;
  localparam integer ARST_CYC = (`TRL_ARST_NS * `TRL_CLK_MHZ + 999) / 1000;
  localparam [11:0] WIN_LAST  = WIN_CYC[11:0] - 12'h001;
  localparam [11:0] ARST_LAST = ARST_CYC[11:0] - 12'h001;

  // Reset sequencer states, one-hot
  localparam [2:0] ST_RUN  = 3'b001;
  localparam [2:0] ST_ARST = 3'b010;
  localparam [2:0] ST_WLCK = 3'b100;

  // Synchronised link side inputs
  wire [NCH-1:0] ref_lk_s;
  wire [NCH-1:0] dat_lk_s;
  wire [NCH-1:0] cal_s;
  wire           lclk_s;

  trl_sync #(.W(3*NCH+1)) u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .d_i      ({tmds_clk_i, cal_busy_i, cdr_data_locked_i, cdr_ref_locked_i}),
    .q_o      ({lclk_s, cal_s, dat_lk_s, ref_lk_s})
  );

  // Control and status state
  reg [3:0]        ctrl_q;     // Software configuration
  reg [`TRL_EV_W-1:0] ist_q;   // Sticky interrupt status
  reg [`TRL_EV_W-1:0] ien_q;   // Interrupt enable
  reg              lclk_d1_q;  // Previous synchronised link clock
  reg [11:0]       win_q;      // Window cycle counter
  reg [RW-1:0]     edge_q;     // Edges in current window
  reg [RW-1:0]     rate_q;     // Last measured bit rate, Mbps
  reg              rate_vld_q; // A measurement has completed
  reg [2:0]        st_q;       // Reset sequencer state
  reg [11:0]       tmr_q;      // Analog reset hold timer
  reg              lock_q;     // All channels locked, last cycle

  wire sym4    = ctrl_q[`TRL_CTRL_SYM4];
  wire ratio40 = ctrl_q[`TRL_CTRL_RATIO40];
  wire rcfhold = ctrl_q[`TRL_CTRL_RCFHOLD];

  // Link clock edge counting over a fixed window
  wire lclk_rise = lclk_s & ~lclk_d1_q;
  wire win_end   = (win_q == WIN_LAST);
  // At 1/40 ratio each link clock stands for four times the bits
  wire [RW+1:0] rate_raw = ratio40 ? {edge_q, 2'b00} : {2'b00, edge_q};
  wire [RW-1:0] rate_new = (|rate_raw[RW+1:RW]) ? {RW{1'b1}} : rate_raw[RW-1:0];

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lclk_d1_q  <= 1'b0;
      win_q      <= 12'h000;
      edge_q     <= {RW{1'b0}};
      rate_q     <= {RW{1'b0}};
      rate_vld_q <= 1'b0;
    end else begin
      lclk_d1_q <= lclk_s;
      if (win_end) begin
        win_q      <= 12'h000;
        edge_q     <= {{(RW-1){1'b0}}, lclk_rise};
        rate_q     <= rate_new;
        rate_vld_q <= 1'b1;
      end else begin
        win_q <= win_q + 12'h001;
        if (lclk_rise && ~&edge_q)
          edge_q <= edge_q + {{(RW-1){1'b0}}, 1'b1};
      end
    end
  end

  // Oversampling decision from rate against width minimum
  wire [RW-1:0] min_rate = sym4 ? `TRL_MIN_RATE_40 : `TRL_MIN_RATE_20;
  wire          osr_new  = rate_vld_q ? (rate_q < min_rate) : oversample_o;
  wire          osr_chg  = osr_new != oversample_o;

  // Lock source picked per channel by the lock mode
  wire [NCH-1:0] sel_lock = oversample_o ? ref_lk_s : dat_lk_s;
  wire           all_lock = &sel_lock;
  wire           cal_act  = (|cal_s) | rcfhold;

  // Decision, clock ratios and lock routing registers
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      oversample_o      <= 1'b0;
      force_ref_lock_o  <= {NCH{1'b0}};
      force_data_lock_o <= {NCH{1'b0}};
      pclk_from_ref_o   <= {NCH{1'b0}};
      lock_to_rstctl_o  <= {NCH{1'b0}};
      cal_active_o      <= 1'b1;
      byte_deser_en_o   <= 1'b0;
      sym_per_clk_o     <= `TRL_SYM2;
      par_data_width_o  <= `TRL_PDW_SYM2;
      refclk_mult_o     <= `TRL_MULT_X1;
      cdr_refclk_sel_o  <= 1'b0;
      lock_q            <= 1'b0;
    end else begin
      oversample_o      <= osr_new;
      force_ref_lock_o  <= {NCH{osr_new}};
      force_data_lock_o <= {NCH{1'b0}};
      pclk_from_ref_o   <= {NCH{osr_new}};
      lock_to_rstctl_o  <= sel_lock;
      cal_active_o      <= cal_act;
      byte_deser_en_o   <= sym4;
      sym_per_clk_o     <= sym4 ? `TRL_SYM4 : `TRL_SYM2;
      par_data_width_o  <= sym4 ? `TRL_PDW_SYM4 : `TRL_PDW_SYM2;
      cdr_refclk_sel_o  <= 1'b0;
      lock_q            <= all_lock;
      // Oversampling outranks the ratio setting
      if (osr_new)
        refclk_mult_o <= `TRL_MULT_X5;
      else if (ratio40)
        refclk_mult_o <= `TRL_MULT_X4;
      else
        refclk_mult_o <= `TRL_MULT_X1;
    end
  end

  // Reset sequencer: analog hold, then digital until locked and calibrated
  reg [2:0]  st_d;
  reg [11:0] tmr_d;
  always @* begin
    st_d  = st_q;
    tmr_d = tmr_q;
    case (st_q)
      ST_RUN: begin
        // A mode change restarts recovery from the analog side
        if (osr_chg) begin
          st_d  = ST_ARST;
          tmr_d = 12'h000;
        end
      end
      ST_ARST: begin
        // A flip during the hold restarts it, so analog reset spans the flip
        if (osr_chg)
          tmr_d = 12'h000;
        else if (tmr_q == ARST_LAST)
          st_d = ST_WLCK;
        else
          tmr_d = tmr_q + 12'h001;
      end
      ST_WLCK: begin
        if (osr_chg) begin
          st_d  = ST_ARST;
          tmr_d = 12'h000;
        end else if (all_lock && !cal_act) begin
          st_d = ST_RUN;
        end
      end
      default: begin
        st_d  = ST_ARST;
        tmr_d = 12'h000;
      end
    endcase
  end

  // Reset outputs are registered from the next state
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q           <= ST_ARST;
      tmr_q          <= 12'h000;
      analog_reset_o <= {NCH{1'b1}};
      digital_reset_o <= {NCH{1'b1}};
    end else begin
      st_q           <= st_d;
      tmr_q          <= tmr_d;
      analog_reset_o <= {NCH{st_d == ST_ARST}};
      digital_reset_o <= {NCH{st_d != ST_RUN}};
    end
  end

  // Interrupt events
  wire [`TRL_EV_W-1:0] ev;
  assign ev[`TRL_EV_MODE]   = osr_chg;
  assign ev[`TRL_EV_LOCK]   = all_lock & ~lock_q;
  assign ev[`TRL_EV_UNLOCK] = ~all_lock & lock_q;

  // AXI write path: address and data held until both present
  reg       aw_hold_q;
  reg       w_hold_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire      wr_go  = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  wire      wr_clr = wr_go && (awaddr_q == `TRL_OFS_IRQ_CLR);
  wire [`TRL_EV_W-1:0] clr_bits = wr_clr ? wdata_q[`TRL_EV_W-1:0] : {`TRL_EV_W{1'b0}};

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TRL_RESP_OK;
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      ctrl_q        <= `TRL_CTRL_RESET;
      ien_q         <= {`TRL_EV_W{1'b0}};
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q      <= s_axi_awaddr;
        aw_hold_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        w_hold_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `TRL_RESP_OK;
        // Only the low byte carries fields
        case (awaddr_q)
          `TRL_OFS_CTRL:    if (wstrb_q[0]) ctrl_q <= wdata_q[3:0];
          `TRL_OFS_IRQ_EN:  if (wstrb_q[0]) ien_q <= wdata_q[`TRL_EV_W-1:0];
          `TRL_OFS_IRQ_CLR: ;
          `TRL_OFS_STATUS,
          `TRL_OFS_IRQ_STAT: ;
          default:          s_axi_bresp <= `TRL_RESP_SLVERR;
        endcase
      end
      // Ready again once the response is taken
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Sticky status: a new event wins over a same-cycle clear
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ist_q <= {`TRL_EV_W{1'b0}};
      irq_o <= 1'b0;
    end else begin
      ist_q <= (ist_q & ~clr_bits) | ev;
      irq_o <= |(((ist_q & ~clr_bits) | ev) & ien_q);
    end
  end

  // Read data mux
  reg [31:0] rd_mux;
  reg        rd_err;
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    case (s_axi_araddr)
      `TRL_OFS_CTRL:     rd_mux = {28'h0000000, ctrl_q};
      `TRL_OFS_STATUS:   rd_mux = {9'h000, st_q, cal_act, all_lock, oversample_o,
                                   rate_vld_q, rate_q};
      `TRL_OFS_IRQ_STAT: rd_mux = {29'h00000000, ist_q};
      `TRL_OFS_IRQ_EN:   rd_mux = {29'h00000000, ien_q};
      `TRL_OFS_IRQ_CLR:  rd_mux = 32'h0000_0000; // Write-only, reads zero
      default:           rd_err = 1'b1;
    endcase
  end

  // AXI read path: one read at a time
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `TRL_RESP_OK;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= rd_err ? `TRL_RESP_SLVERR : `TRL_RESP_OK;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

/* File: trl_rate_lock_props.sv */
// Concurrent checks on the rate and lock controller ports
`timescale 1ns/1ps
`default_nettype none
module trl_rate_lock_props #(
  parameter NCH = 3  // Channel count, handed on by the bind
) (
  input wire logic           clk_i,
  input wire logic           resetn_i,
  input wire logic [NCH-1:0] cdr_ref_locked_i,
  input wire logic [NCH-1:0] cdr_data_locked_i,
  input wire logic [NCH-1:0] cal_busy_i,
  input wire logic [NCH-1:0] force_ref_lock_o,
  input wire logic [NCH-1:0] force_data_lock_o,
  input wire logic [NCH-1:0] pclk_from_ref_o,
  input wire logic [NCH-1:0] analog_reset_o,
  input wire logic [NCH-1:0] digital_reset_o,
  input wire logic [NCH-1:0] lock_to_rstctl_o,
  input wire logic           cal_active_o,
  input wire logic           oversample_o,
  input wire logic           byte_deser_en_o,
  input wire logic [2:0]     sym_per_clk_o,
  input wire logic [7:0]     par_data_width_o,
  input wire logic [2:0]     refclk_mult_o,
  input wire logic           cdr_refclk_sel_o
);
  // One clock domain; every check sleeps through reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  property p_fdl; force_data_lock_o == '0; endproperty
  a_fdl: assert property (p_fdl) else $error("data lock forced");
  property p_frl; force_ref_lock_o == {NCH{oversample_o}}; endproperty
  a_frl: assert property (p_frl) else $error("ref lock off decision");
  property p_pclk; pclk_from_ref_o == force_ref_lock_o; endproperty
  a_pclk: assert property (p_pclk) else $error("pclk source wrong");
  property p_mult; oversample_o [*2] |-> refclk_mult_o == 3'h5; endproperty
  a_mult: assert property (p_mult) else $error("refclk not x5");
  // Widths are registered in the same cycle as the symbol count
  property p_deser; $stable(sym_per_clk_o) |-> byte_deser_en_o == (sym_per_clk_o == 3'h4);
  endproperty
  a_deser: assert property (p_deser) else $error("byte deser wrong");
  property p_width; $stable(sym_per_clk_o) |-> par_data_width_o == {5'h00, sym_per_clk_o} * 8'h1E;
  endproperty
  a_width: assert property (p_width) else $error("data width wrong");
  property p_sel; cdr_refclk_sel_o == 1'b0; endproperty
  a_sel: assert property (p_sel) else $error("ref input moved");
  // A mode flip puts every channel back into reset
  property p_mode; $changed(oversample_o) |-> &analog_reset_o && &digital_reset_o; endproperty
  a_mode: assert property (p_mode) else $error("no reset on mode flip");
  property p_hold; analog_reset_o[0] |-> digital_reset_o[0]; endproperty
  a_hold: assert property (p_hold) else $error("digital out early");
  property p_cal; cal_busy_i[0] [*5] |-> cal_active_o; endproperty
  a_cal: assert property (p_cal) else $error("cal busy not shown");
  // Sync stages need a few cycles before routing settles
  property p_lkref;
    (force_ref_lock_o[0] && cdr_ref_locked_i[0] && !cdr_data_locked_i[0]) [*6]
      |-> lock_to_rstctl_o[0];
  endproperty
  a_lkref: assert property (p_lkref) else $error("ref lock not routed");
  property p_lkdat;
    (!force_ref_lock_o[0] && cdr_ref_locked_i[0] && !cdr_data_locked_i[0]) [*6]
      |-> !lock_to_rstctl_o[0];
  endproperty
  a_lkdat: assert property (p_lkdat) else $error("data lock not routed");
endmodule
bind trl_rate_lock_ctrl trl_rate_lock_props #(.NCH(NCH)) trl_rate_lock_props_inst (
  .clk_i(clk_i), .resetn_i(resetn_i), .cdr_ref_locked_i(cdr_ref_locked_i),
  .cdr_data_locked_i(cdr_data_locked_i), .cal_busy_i(cal_busy_i),
  .force_ref_lock_o(force_ref_lock_o), .force_data_lock_o(force_data_lock_o),
  .pclk_from_ref_o(pclk_from_ref_o), .analog_reset_o(analog_reset_o),
  .digital_reset_o(digital_reset_o), .lock_to_rstctl_o(lock_to_rstctl_o),
  .cal_active_o(cal_active_o), .oversample_o(oversample_o), .byte_deser_en_o(byte_deser_en_o),
  .sym_per_clk_o(sym_per_clk_o), .par_data_width_o(par_data_width_o),
  .refclk_mult_o(refclk_mult_o), .cdr_refclk_sel_o(cdr_refclk_sel_o));
`default_nettype wire

/* File: trl_link_src.sv */
// Behavioural video source that makes the link clock
`timescale 1ns/1ps
`default_nettype none
module trl_link_src #(
  parameter real HALF_NS = 24.0  // Half of the 48 ns link period
) (
  input  wire logic en_i,        // Source present and sending
  output var logic  tmds_clk_o   // Link clock, parked low while idle
);
  // Odd start offset keeps phase unrelated to the system clock
  initial begin
    tmds_clk_o = 1'b0;
    #1.3;
    forever begin
      #(HALF_NS);
      tmds_clk_o = en_i ? ~tmds_clk_o : 1'b0;  // Tenth of the bit rate
    end
  end
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the rate and lock controller
`timescale 1ns/1ps
`default_nettype none
`include "trl_defs.vh"
module testbench;
  logic        clk_i    = 1'b0;  // System clock
  logic        resetn_i = 1'b0;  // Held low at start
  logic [7:0]  awaddr   = 8'h00; // Write address
  logic [7:0]  araddr   = 8'h00; // Read address
  logic [31:0] wdata    = 32'h0; // Write word
  logic        awvalid  = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid  = 1'b0, rready = 1'b0;
  logic        link_en  = 1'b0;  // Source sending
  logic [2:0]  ref_lk   = 3'h0;  // CDR locked to reference
  logic [2:0]  dat_lk   = 3'h0;  // CDR locked to data
  logic [2:0]  cal      = 3'h0;  // Calibration busy
  logic [31:0] rd;               // Last read word
  logic [1:0]  rsp;              // Last response
  int          fail_count = 0, tests_run = 0, cyc = 0;
  wire         awready, wready, bvalid, arready, rvalid, tmds_clk;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [2:0]   frl, fdl, pcr, arst, drst, lkr, spc, mult;
  wire         cal_act, ovs, bde, rsel, irq;
  wire [7:0]   pwid;
  trl_link_src trl_link_src_inst (.en_i(link_en), .tmds_clk_o(tmds_clk));
  trl_rate_lock_ctrl #(.NCH(3)) trl_rate_lock_ctrl_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tmds_clk_i(tmds_clk), .cdr_ref_locked_i(ref_lk), .cdr_data_locked_i(dat_lk),
    .cal_busy_i(cal), .force_ref_lock_o(frl), .force_data_lock_o(fdl), .pclk_from_ref_o(pcr),
    .analog_reset_o(arst), .digital_reset_o(drst), .lock_to_rstctl_o(lkr),
    .cal_active_o(cal_act), .oversample_o(ovs), .byte_deser_en_o(bde), .sym_per_clk_o(spc),
    .par_data_width_o(pwid), .refclk_mult_o(mult), .cdr_refclk_sel_o(rsel), .irq_o(irq));
  // 200 MHz clock
  initial forever #2.5 clk_i = ~clk_i;
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Bus write: each channel released at its own handshake
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    rsp = bresp;
    @(posedge clk_i);
  endtask
  // Bus read
  task automatic rd_reg(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rd = rdata;
    rsp = rresp;
    @(posedge clk_i);
  endtask
  // Hang guard, well past the three 4100-cycle rate waits
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    chk({arst, spc, pwid, mult}, {3'h7, `TRL_SYM2, 8'h3C, `TRL_MULT_X1});
    rd_reg(`TRL_OFS_CTRL);
    chk(rd, 32'h0);
    rd_reg(8'h14);
    chk({rsp, rd}, {`TRL_RESP_SLVERR, 32'h0});
    wr_reg(8'h20, 32'h1);
    chk(rsp, `TRL_RESP_SLVERR);
    // Slow source: about 208 Mbps at the tenth ratio
    wr_reg(`TRL_OFS_IRQ_EN, 32'h1);
    link_en <= 1'b1;
    ref_lk <= 3'h7;
    repeat (4100) @(posedge clk_i);
    chk({ovs, frl, fdl, mult, rsel}, {1'b1, 3'h7, 3'h0, `TRL_MULT_X5, 1'b0});
    chk({lkr, drst, irq}, {3'h7, 3'h0, 1'b1});
    chk(pcr, 3'h7);
    rd_reg(`TRL_OFS_STATUS);
    chk(rd[17:16], 2'h3);
    wr_reg(`TRL_OFS_IRQ_CLR, 32'h1);
    wr_reg(`TRL_OFS_IRQ_EN, 32'h0);
    rd_reg(`TRL_OFS_IRQ_STAT);
    chk({rd[2:0], irq}, {3'h2, 1'b0});
    // Four symbols at 1/40: 832 Mbps, still under the wide floor
    wr_reg(`TRL_OFS_CTRL, 32'h3);
    repeat (4100) @(posedge clk_i);
    chk({ovs, bde, spc, pwid}, {1'b1, 1'b1, `TRL_SYM4, 8'h78});
    // Two symbols at 1/40: 832 Mbps recovers directly
    wr_reg(`TRL_OFS_CTRL, 32'h2);
    repeat (4100) @(posedge clk_i);
    chk({ovs, frl, pcr, mult}, {1'b0, 3'h0, 3'h0, `TRL_MULT_X4});
    chk({lkr, drst, irq}, {3'h0, 3'h7, 1'b0});
    dat_lk <= 3'h7;
    repeat (10) @(posedge clk_i);
    chk({lkr, drst}, {3'h7, 3'h0});
    wr_reg(`TRL_OFS_IRQ_EN, 32'h1);
    repeat (3) @(posedge clk_i);
    chk(irq, 1'b1);
    // Calibration and reconfig hold both show as busy
    cal <= 3'h1;
    repeat (8) @(posedge clk_i);
    chk(cal_act, 1'b1);
    cal <= 3'h0;
    wr_reg(`TRL_OFS_CTRL, 32'h6);
    repeat (3) @(posedge clk_i);
    chk(cal_act, 1'b1);
    wr_reg(`TRL_OFS_CTRL, 32'h2);
    repeat (3) @(posedge clk_i);
    chk(cal_act, 1'b0);
    // Reset in mid-run returns every output to its reset level
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({arst, drst, cal_act, ovs, mult, irq}, {3'h7, 3'h7, 1'b1, 1'b0, `TRL_MULT_X1, 1'b0});
    resetn_i <= 1'b1;
    @(posedge clk_i);
    rd_reg(`TRL_OFS_CTRL);
    chk(rd, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
